// *** logic/pcr_pkg.sv ***
// Shared constants and types for the core clock/reset interface.
// Assumes a single system clock of 25 MHz and a synchronous active-high reset.
package pcr_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 40;
   // Core output clock divider: half period in system clocks
   localparam int unsigned CORE_DIV_HALF   = 1;
   // Time in ns of stable output clock before the lock indication
   localparam int unsigned LOCK_WAIT_NS    = 400;
   localparam int unsigned LOCK_WAIT_CYC   = (LOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Internal reset of the core clock domain after release
   localparam int unsigned HIP_RST_NS      = 320;
   localparam int unsigned HIP_RST_CYC     = (HIP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 8;
   localparam logic        RST_STATUS_INIT = 1'b1;

   typedef enum logic [1:0] {PCR_HELD, PCR_LOCKWAIT, PCR_HIPRST, PCR_RUN} pcr_state_t;
endpackage

// *** logic/pcr_if.sv ***
// Interface joining the core end and the application end.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface pcr_if;
   logic core_rst_n;     // Active-low core reset, formed by the application
   logic pin_rst_n;      // Board reset pin, passed through the application end
   logic core_clk_out;   // Fixed-frequency output clock of the core
   logic app_clk_in;     // Application clock fed back to the core
   logic pll_locked;
   logic core_ready;
   logic clk_in_use;
   logic reset_status;

   modport core
   (
      input  core_rst_n,
      input  pin_rst_n,
      input  app_clk_in,
      input  core_ready,
      output core_clk_out,
      output pll_locked,
      output clk_in_use,
      output reset_status
   );
   modport app
   (
      output core_rst_n,
      output pin_rst_n,
      output app_clk_in,
      output core_ready,
      input  core_clk_out,
      input  pll_locked,
      input  clk_in_use,
      input  reset_status
   );
endinterface

// *** logic/pcr_core.sv ***
// Core end: output clock generation, reset controller and reset status.
// Assumes the application forms the core reset and returns the core clock.
`timescale 1ns/1ns
// Function
// - System supplies reference clock at configured frequency
// - Application clock driven from core output clock
// - Core makes fixed-frequency output clock
// - Core reset is board OR soft reset
// - Without soft reset, use board reset only
// - Core reset asynchronous, holds whole core
// - Reset status high while core in reset
// - Status clears after release and internal reset
// - Application resets itself from reset status
// - Board reset clears datapath and control registers
// - Board reset connected for link configuration
// - Each instance tied to its own reset pin
// - Ready only once application clock is stable
// - Clock-in-use flag; application waits for it
module pcr_core
   import pcr_pkg::*;
(
   input  wire logic CLK_SYS,      // Reference clock
   input  wire logic SRST,
   pcr_if.core       LNK,
   output logic      DATA_VALID,   // Datapath register shows live data
   input  wire logic DATA_IN,
   output logic      DATA_OUT
);
   typedef struct packed
   {
      pcr_state_t       state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] div;
      logic             clk_out;
      logic             locked;
      logic             in_use;
      logic             rst_status;
      logic             data_valid;
      logic             data;
   } pcr_core_st_t;

   pcr_core_st_t st;
   pcr_core_st_t next_st;
   logic         async_rst;
   logic         rst_m;
   logic         rst_q;

   // Pin reset and core reset both clear the core
   assign async_rst = SRST | ~LNK.core_rst_n | ~LNK.pin_rst_n;

   // Release of the asynchronous reset is synchronised before use
   always_ff @(posedge CLK_SYS or posedge async_rst)
   begin
      if (async_rst)
      begin
         rst_m <= 1'b1;
         rst_q <= 1'b1;
      end
      else
      begin
         rst_m <= 1'b0;
         rst_q <= rst_m;
      end
   end

   always_comb
   begin
      next_st = st;
      // Free-running divider: fixed output frequency
      if (st.div == CNT_W'(CORE_DIV_HALF - 1))
      begin
         next_st.div     = '0;
         next_st.clk_out = ~st.clk_out;
      end
      else
      begin
         next_st.div = st.div + 1'b1;
      end
      next_st.data_valid = 1'b0;
      next_st.data       = 1'b0;
      case (st.state)
         PCR_HELD:
         begin
            next_st.cnt   = '0;
            next_st.state = PCR_LOCKWAIT;
         end
         PCR_LOCKWAIT:
         begin
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt == CNT_W'(LOCK_WAIT_CYC - 1))
            begin
               next_st.locked = 1'b1;
               next_st.cnt    = '0;
               next_st.state  = PCR_HIPRST;
            end
         end
         PCR_HIPRST:
         begin
            // Core waits for the application to confirm a stable clock
            if (LNK.core_ready)
            begin
               next_st.in_use = 1'b1;
               next_st.cnt    = st.cnt + 1'b1;
               if (st.cnt == CNT_W'(HIP_RST_CYC - 1))
               begin
                  next_st.rst_status = 1'b0;
                  next_st.state      = PCR_RUN;
               end
            end
         end
         PCR_RUN:
         begin
            next_st.data_valid = 1'b1;
            next_st.data       = DATA_IN;
         end
         default:
         begin
            next_st.state = PCR_HELD;
         end
      endcase
   end

   // Whole state cleared while in reset; status held high
   always_ff @(posedge CLK_SYS or posedge async_rst)
   begin
      if (async_rst)
      begin
         st            <= '0;
         st.state      <= PCR_HELD;
         st.rst_status <= RST_STATUS_INIT;
      end
      else if (rst_q)
      begin
         st            <= '0;
         st.state      <= PCR_HELD;
         st.rst_status <= RST_STATUS_INIT;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign LNK.core_clk_out = st.clk_out;
   assign LNK.pll_locked   = st.locked;
   assign LNK.clk_in_use   = st.in_use;
   assign LNK.reset_status = st.rst_status;
   assign DATA_VALID       = st.data_valid;
   assign DATA_OUT         = st.data;
endmodule

// *** logic/pcr_app.sv ***
// Application end: forms the core reset and its own reset from status.
// Assumes the board reset pin arrives synchronous to the system clock.
`timescale 1ns/1ns
module pcr_app
   import pcr_pkg::*;
(
   input  wire logic CLK_SYS,
   input  wire logic SRST,
   pcr_if.app        LNK,
   input  wire logic PIN_RST_N,     // Board reset pin
   input  wire logic SOFT_RST_N,    // Tie high when no soft reset is used
   output logic      APP_RST
);
   typedef struct packed
   {
      logic core_rst_n;
      logic app_rst;
   } pcr_app_st_t;

   pcr_app_st_t st;
   pcr_app_st_t next_st;

   always_comb
   begin
      next_st = st;
      // Either reset source resets the core
      next_st.core_rst_n = PIN_RST_N & SOFT_RST_N;
      // Stay in reset until status clears and clock in use
      next_st.app_rst = LNK.reset_status | ~LNK.clk_in_use;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         st.core_rst_n <= 1'b0;
         st.app_rst    <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign LNK.core_rst_n = st.core_rst_n;
   assign LNK.pin_rst_n  = PIN_RST_N;
   assign LNK.app_clk_in = LNK.core_clk_out;
   assign LNK.core_ready = LNK.pll_locked;
   assign APP_RST        = st.app_rst;
endmodule

// *** sim/pcr_checker.sv ***
// Assertions on the clock and reset link between the two ends.
// Assumes one system clock; sits beside the interface in tb_top.
`timescale 1ns/1ns
module pcr_checker
(
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic core_rst_n,
   input wire logic pin_rst_n,
   input wire logic core_clk_out,
   input wire logic app_clk_in,
   input wire logic pll_locked,
   input wire logic core_ready,
   input wire logic clk_in_use,
   input wire logic reset_status
);
   default clocking dc @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   chk_status_in_rst: assert property (!core_rst_n |-> reset_status)
      else $error("status low while core reset");
   chk_pin_holds: assert property (!pin_rst_n |-> reset_status && !pll_locked)
      else $error("board reset did not hold core");
   chk_core_rst_form: assert property ($past(!pin_rst_n) |-> !core_rst_n)
      else $error("core reset not formed from board reset");
   chk_clk_fixed: assert property (pll_locked && $past(pll_locked) |-> $changed(core_clk_out))
      else $error("output clock stalled");
   chk_app_clk_src: assert property (app_clk_in == core_clk_out)
      else $error("application clock not from core clock");
   chk_ready_lock: assert property (core_ready == pll_locked)
      else $error("ready without lock");
   chk_inuse_next: assert property ($rose(pll_locked) |=> clk_in_use)
      else $error("clock in use late");
   chk_status_order: assert property (!reset_status |-> clk_in_use && core_rst_n)
      else $error("status cleared too early");
   chk_status_clear: assert property (disable iff (SRST || !core_rst_n)
      $rose(clk_in_use) |-> ##[1:20] !reset_status)
      else $error("status never cleared");
   cover property ($fell(reset_status));
   cover property ($fell(pin_rst_n));
   cover property ($rose(pll_locked));
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench: both ends joined, soft, pin and system resets pulsed in turn for random lengths.
// Assumes the interface and both ends from logic/.
`timescale 1ns/1ns
module tb_top;
   import pcr_pkg::*;
   logic clk    = 1'b0;
   logic srst   = 1'b1;
   logic pin_n  = 1'b1;
   logic soft_n = 1'b1;
   logic din    = 1'b0;
   logic dvalid;
   logic dout;
   logic app_rst;
   int   fails   = 0;
   int   checked = 0;
   int   seed    = 18434;
   int   n;
   int   m;
   pcr_if lnk ();
   pcr_core pcr_core_i (.CLK_SYS(clk), .SRST(srst), .LNK(lnk), .DATA_VALID(dvalid),
      .DATA_IN(din), .DATA_OUT(dout));
   pcr_app pcr_app_i (.CLK_SYS(clk), .SRST(srst), .LNK(lnk), .PIN_RST_N(pin_n),
      .SOFT_RST_N(soft_n), .APP_RST(app_rst));
   pcr_checker pcr_checker_i (.CLK_SYS(clk), .SRST(srst), .core_rst_n(lnk.core_rst_n),
      .pin_rst_n(lnk.pin_rst_n), .core_clk_out(lnk.core_clk_out),
      .app_clk_in(lnk.app_clk_in), .pll_locked(lnk.pll_locked),
      .core_ready(lnk.core_ready), .clk_in_use(lnk.clk_in_use),
      .reset_status(lnk.reset_status));
   // Reference clock at the configured 25 MHz
   always #20 clk = ~clk;
   function automatic logic exp_core_n(input logic p, input logic s);
      return p & s;
   endfunction
   task automatic check(input logic seen, input logic exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %b expected %b", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Bounded wait; a hang here shows as a mismatch, not a stall
   task automatic bring_up;
      n = 0;
      while (app_rst !== 1'b0 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      check(n < 200, 1'b1);
      check(lnk.pll_locked, 1'b1);
      check(lnk.clk_in_use, 1'b1);
      check(lnk.reset_status, 1'b0);
      @(negedge clk);
      check(dvalid, 1'b1);
      repeat (8)
      begin
         din = 1'($random(seed));
         @(negedge clk);
         check(dout, din);
      end
   endtask
   initial
   begin
      repeat (8) @(negedge clk);
      srst = 1'b0;
      bring_up();
      $display("test bring-up done");
      for (int k = 0; k < 9; k++)
      begin
         m = k % 3;
         if (m == 0)
            soft_n = 1'b0;
         else if (m == 1)
            pin_n = 1'b0;
         else
            srst = 1'b1;
         repeat (2 + ($unsigned($random(seed)) % 4)) @(negedge clk);
         check(lnk.core_rst_n, (m == 2) ? 1'b0 : exp_core_n(pin_n, soft_n));
         check(lnk.reset_status, 1'b1);
         check(lnk.pll_locked, 1'b0);
         check(dvalid, 1'b0);
         check(dout, 1'b0);
         check(app_rst, 1'b1);
         soft_n = 1'b1;
         pin_n  = 1'b1;
         srst   = 1'b0;
         bring_up();
         $display("test reset mode %0d done", m);
      end
      finish_test();
   end
   initial
   begin
      #(40 * 4000);
      fails++;
      finish_test();
   end
endmodule
